// *** design/rtd_driver_config.sv ***
// register bank and driver pin logic of the transmitter driver stage
`default_nettype none
module rtd_driver_config #(
  parameter int OVS_W = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // carrier and modulation sources
  input  wire logic        carrier_in,
  input  wire logic        carrier_tick,
  input  wire logic        internal_envelope_signal,
  input  wire logic        external_modulation_input,
  // driver pins
  output logic             driver_out_first_o,
  output logic             driver_out_first_oe,
  output logic             driver_out_second_o,
  output logic             driver_out_second_oe,
  // analog control
  output logic [1:0]       carrier_level_reduction,
  output logic             carrier_full_level,
  output logic [4:0]       residual_level,
  output logic [3:0]       load_current_trim,
  output logic             modulation_active,
  output logic             overshoot_first_active,
  output logic             overshoot_extra_active
);

  function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
    idx_hit = (addr[rtd_pkg::ADDR_LSB-1:0] == '0)
           && (addr[rtd_pkg::ADDR_W-1:rtd_pkg::ADDR_LSB] == {2'h0, idx});
  endfunction

  function automatic logic decode(input logic [11:0] addr, output rtd_pkg::rtd_reg_sel_type sel);
    logic hit;
    hit = 1'b1;
    sel = rtd_pkg::RTD_REG_MODE;
    if (idx_hit(addr, rtd_pkg::IDX_DRIVER_MODE)) begin
      sel = rtd_pkg::RTD_REG_MODE;
    end else if (idx_hit(addr, rtd_pkg::IDX_CARRIER_AMP)) begin
      sel = rtd_pkg::RTD_REG_AMP;
    end else if (idx_hit(addr, rtd_pkg::IDX_MODULATION)) begin
      sel = rtd_pkg::RTD_REG_MOD;
    end else if (idx_hit(addr, rtd_pkg::IDX_OVERSHOOT_LD)) begin
      sel = rtd_pkg::RTD_REG_OVS;
    end else begin
      hit = 1'b0;
    end
    decode = hit;
  endfunction

  // ---------------- bus and register state ----------------
  logic [7:0]  driver_mode_ctrl_reg;
  logic [7:0]  driver_mode_ctrl_next;
  logic [7:0]  carrier_amplitude_ctrl_reg;
  logic [7:0]  carrier_amplitude_ctrl_next;
  logic [7:0]  modulation_ctrl_reg;
  logic [7:0]  modulation_ctrl_next;
  logic [7:0]  overshoot_load_ctrl_reg;
  logic [7:0]  overshoot_load_ctrl_next;
  logic        aw_held_reg;
  logic        aw_held_next;
  logic [11:0] aw_addr_reg;
  logic [11:0] aw_addr_next;
  logic        w_held_reg;
  logic        w_held_next;
  logic [7:0]  w_data_reg;
  logic [7:0]  w_data_next;
  logic        w_strb_reg;
  logic        w_strb_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;

  // address and data are taken independently; the write lands when both are held
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    rtd_pkg::rtd_reg_sel_type wsel;
    rtd_pkg::rtd_reg_sel_type rsel;
    logic                     whit;
    logic                     rhit;
    logic [7:0]               rbyte;
    wsel = rtd_pkg::RTD_REG_MODE;
    rsel = rtd_pkg::RTD_REG_MODE;
    rbyte = 8'h00;
    whit = 1'b0;
    rhit = 1'b0;
    driver_mode_ctrl_next       = driver_mode_ctrl_reg;
    carrier_amplitude_ctrl_next = carrier_amplitude_ctrl_reg;
    modulation_ctrl_next        = modulation_ctrl_reg;
    overshoot_load_ctrl_next    = overshoot_load_ctrl_reg;
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;

    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata[7:0];
      w_strb_next = s_axi_wstrb[0];
    end
    whit = decode(aw_addr_reg, wsel);
    if (aw_held_reg && w_held_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = whit ? rtd_pkg::RESP_OKAY : rtd_pkg::RESP_SLVERR;
      // only byte lane 0 carries register data
      if (whit && w_strb_reg) begin
        unique case (wsel)
          rtd_pkg::RTD_REG_MODE:
            driver_mode_ctrl_next = w_data_reg & rtd_pkg::MASK_DRIVER_MODE;
          rtd_pkg::RTD_REG_AMP:
            carrier_amplitude_ctrl_next = w_data_reg & rtd_pkg::MASK_CARRIER_AMP;
          rtd_pkg::RTD_REG_MOD:
            modulation_ctrl_next = w_data_reg & rtd_pkg::MASK_MODULATION;
          rtd_pkg::RTD_REG_OVS:
            overshoot_load_ctrl_next = w_data_reg & rtd_pkg::MASK_OVERSHOOT_LD;
        endcase
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end

    rhit = decode(s_axi_araddr, rsel);
    if (s_axi_arvalid && s_axi_arready) begin
      unique case (rsel)
        rtd_pkg::RTD_REG_MODE: rbyte = driver_mode_ctrl_reg;
        rtd_pkg::RTD_REG_AMP:  rbyte = carrier_amplitude_ctrl_reg;
        rtd_pkg::RTD_REG_MOD:  rbyte = modulation_ctrl_reg;
        rtd_pkg::RTD_REG_OVS:  rbyte = overshoot_load_ctrl_reg;
      endcase
      rvalid_next = 1'b1;
      rdata_next  = rhit ? {24'h000000, rbyte} : 32'h00000000;
      rresp_next  = rhit ? rtd_pkg::RESP_OKAY : rtd_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_mode_ctrl_reg       <= rtd_pkg::RST_DRIVER_MODE;
      carrier_amplitude_ctrl_reg <= rtd_pkg::RST_CARRIER_AMP;
      modulation_ctrl_reg        <= rtd_pkg::RST_MODULATION;
      overshoot_load_ctrl_reg    <= rtd_pkg::RST_OVERSHOOT_LD;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= rtd_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= rtd_pkg::RESP_OKAY;
    end else begin
      driver_mode_ctrl_reg       <= driver_mode_ctrl_next;
      carrier_amplitude_ctrl_reg <= carrier_amplitude_ctrl_next;
      modulation_ctrl_reg        <= modulation_ctrl_next;
      overshoot_load_ctrl_reg    <= overshoot_load_ctrl_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ---------------- modulation path ----------------
  logic             mod_raw;
  logic             mod_src;
  logic             mod_reg;
  logic             mod_next;
  logic             first_busy;
  logic             extra_busy;
  logic [2:0]       style;

  always_comb begin
    unique case (modulation_ctrl_reg[rtd_pkg::SRC_MSB:rtd_pkg::SRC_LSB])
      rtd_pkg::SRC_NONE:     mod_src = 1'b0;
      rtd_pkg::SRC_ENVELOPE: mod_src = internal_envelope_signal;
      rtd_pkg::SRC_EXTERNAL: mod_src = external_modulation_input;
      rtd_pkg::SRC_RESERVED: mod_src = 1'b0;
    endcase
    mod_raw = mod_src ^ modulation_ctrl_reg[rtd_pkg::BIT_MOD_INVERT];
    mod_next = mod_raw;
  end

  rtd_carrier_timer #(.LEN_W(OVS_W)) u_first_stage (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .start        (mod_raw && !mod_reg),
    .length       (overshoot_load_ctrl_reg[rtd_pkg::FIRST_MSB:rtd_pkg::FIRST_LSB]),
    .carrier_tick (carrier_tick),
    .busy         (first_busy)
  );

  rtd_carrier_timer #(.LEN_W(OVS_W)) u_extra_stage (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .start        (!mod_raw && mod_reg),
    .length       (modulation_ctrl_reg[rtd_pkg::EXTRA_MSB:rtd_pkg::EXTRA_LSB]),
    .carrier_tick (carrier_tick),
    .busy         (extra_busy)
  );

  // ---------------- pin and analog outputs ----------------
  logic       first_o_next;
  logic       first_oe_next;
  logic       second_o_next;
  logic       second_oe_next;
  logic [1:0] reduce_next;
  logic       first_o_reg;
  logic       first_oe_reg;
  logic       second_o_reg;
  logic       second_oe_reg;
  logic [1:0] reduce_reg;
  logic       full_reg;
  logic [4:0] resid_reg;
  logic [3:0] trim_reg;
  logic       mod_act_reg;
  logic       first_act_reg;
  logic       extra_act_reg;

  function automatic logic [1:0] pin_drive(input logic [2:0] sty, input logic en,
                                           input logic lvl);
    // returns {output enable, output level}
    logic [1:0] r;
    r = 2'h0;
    if (en) begin
      unique case (sty)
        rtd_pkg::STYLE_PUSH_PULL,
        rtd_pkg::STYLE_PUSH_ALT:   r = {1'b1, lvl};
        rtd_pkg::STYLE_OPEN_DRAIN: r = {!lvl, 1'b0};
        rtd_pkg::STYLE_FORCE_LOW:  r = 2'h2;
        rtd_pkg::STYLE_FORCE_HIGH: r = 2'h3;
        // high-Z and the unsupported codes float the pins for safety
        rtd_pkg::STYLE_HIGH_Z,
        rtd_pkg::STYLE_BAD_A,
        rtd_pkg::STYLE_BAD_B:      r = 2'h0;
      endcase
    end
    pin_drive = r;
  endfunction

  assign style = driver_mode_ctrl_reg[rtd_pkg::STYLE_MSB:rtd_pkg::STYLE_LSB];

  always_comb begin
    {first_oe_next, first_o_next} = pin_drive(style,
        driver_mode_ctrl_reg[rtd_pkg::BIT_PINS_ENABLE],
        carrier_in ^ driver_mode_ctrl_reg[rtd_pkg::BIT_FIRST_INV]);
    {second_oe_next, second_o_next} = pin_drive(style,
        driver_mode_ctrl_reg[rtd_pkg::BIT_PINS_ENABLE],
        carrier_in ^ driver_mode_ctrl_reg[rtd_pkg::BIT_SECOND_INV]);
    if (modulation_ctrl_reg[rtd_pkg::BIT_FULL_LEVEL]) begin
      reduce_next = rtd_pkg::REDUCE_NONE;
    end else begin
      reduce_next = carrier_amplitude_ctrl_reg[rtd_pkg::REDUCE_MSB:rtd_pkg::REDUCE_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_reg       <= 1'b0;
      first_o_reg   <= 1'b0;
      first_oe_reg  <= 1'b0;
      second_o_reg  <= 1'b0;
      second_oe_reg <= 1'b0;
      reduce_reg    <= 2'h0;
      full_reg      <= 1'b0;
      resid_reg     <= 5'h00;
      trim_reg      <= 4'h0;
      mod_act_reg   <= 1'b0;
      first_act_reg <= 1'b0;
      extra_act_reg <= 1'b0;
    end else begin
      mod_reg       <= mod_next;
      first_o_reg   <= first_o_next;
      first_oe_reg  <= first_oe_next;
      second_o_reg  <= second_o_next;
      second_oe_reg <= second_oe_next;
      reduce_reg    <= reduce_next;
      full_reg      <= modulation_ctrl_reg[rtd_pkg::BIT_FULL_LEVEL];
      resid_reg     <= carrier_amplitude_ctrl_reg[rtd_pkg::RESID_MSB:rtd_pkg::RESID_LSB];
      trim_reg      <= overshoot_load_ctrl_reg[rtd_pkg::TRIM_MSB:rtd_pkg::TRIM_LSB];
      mod_act_reg   <= mod_reg || extra_busy;
      first_act_reg <= first_busy;
      extra_act_reg <= extra_busy;
    end
  end

  assign driver_out_first_o      = first_o_reg;
  assign driver_out_first_oe     = first_oe_reg;
  assign driver_out_second_o     = second_o_reg;
  assign driver_out_second_oe    = second_oe_reg;
  assign carrier_level_reduction = reduce_reg;
  assign carrier_full_level      = full_reg;
  assign residual_level          = resid_reg;
  assign load_current_trim       = trim_reg;
  assign modulation_active       = mod_act_reg;
  assign overshoot_first_active  = first_act_reg;
  assign overshoot_extra_active  = extra_act_reg;

endmodule
`default_nettype wire

// *** include/rtd_pkg.sv ***
// constants and types for the transmitter driver configuration block
`default_nettype none
package rtd_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DRIVER_MODE   = 8'h28;
  localparam logic [7:0] IDX_CARRIER_AMP   = 8'h29;
  localparam logic [7:0] IDX_MODULATION    = 8'h2A;
  localparam logic [7:0] IDX_OVERSHOOT_LD  = 8'h2B;
  localparam int         ADDR_LSB          = 2;
  localparam int         ADDR_W            = 12;

  // reset values of the four registers
  localparam logic [7:0] RST_DRIVER_MODE   = 8'h00;
  localparam logic [7:0] RST_CARRIER_AMP   = 8'h00;
  localparam logic [7:0] RST_MODULATION    = 8'h00;
  localparam logic [7:0] RST_OVERSHOOT_LD  = 8'h00;

  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_DRIVER_MODE  = 8'hCF;
  localparam logic [7:0] MASK_CARRIER_AMP  = 8'hDF;
  localparam logic [7:0] MASK_MODULATION   = 8'hFF;
  localparam logic [7:0] MASK_OVERSHOOT_LD = 8'hFF;

  // driver mode fields
  localparam int BIT_SECOND_INV  = 7;
  localparam int BIT_FIRST_INV   = 6;
  localparam int BIT_PINS_ENABLE = 3;
  localparam int STYLE_MSB       = 2;
  localparam int STYLE_LSB       = 0;
  // amplitude fields
  localparam int REDUCE_MSB      = 7;
  localparam int REDUCE_LSB      = 6;
  localparam int RESID_MSB       = 4;
  localparam int RESID_LSB       = 0;
  // modulation control fields
  localparam int EXTRA_MSB       = 7;
  localparam int EXTRA_LSB       = 4;
  localparam int BIT_FULL_LEVEL  = 3;
  localparam int BIT_MOD_INVERT  = 2;
  localparam int SRC_MSB         = 1;
  localparam int SRC_LSB         = 0;
  // overshoot and load fields
  localparam int FIRST_MSB       = 7;
  localparam int FIRST_LSB       = 4;
  localparam int TRIM_MSB        = 3;
  localparam int TRIM_LSB        = 0;

  // driver output style codes
  localparam logic [2:0] STYLE_PUSH_PULL  = 3'h0;
  localparam logic [2:0] STYLE_OPEN_DRAIN = 3'h1;
  localparam logic [2:0] STYLE_HIGH_Z     = 3'h2;
  localparam logic [2:0] STYLE_BAD_A      = 3'h3;
  localparam logic [2:0] STYLE_FORCE_LOW  = 3'h4;
  localparam logic [2:0] STYLE_FORCE_HIGH = 3'h5;
  localparam logic [2:0] STYLE_BAD_B      = 3'h6;
  localparam logic [2:0] STYLE_PUSH_ALT   = 3'h7;

  // modulation source codes
  localparam logic [1:0] SRC_NONE     = 2'h0;
  localparam logic [1:0] SRC_ENVELOPE = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_RESERVED = 2'h3;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [1:0] REDUCE_NONE  = 2'h0;

  typedef enum logic [1:0] {
    RTD_REG_MODE,
    RTD_REG_AMP,
    RTD_REG_MOD,
    RTD_REG_OVS
  } rtd_reg_sel_type;
endpackage
`default_nettype wire

// *** design/rtd_carrier_timer.sv ***
// down counter of carrier clock ticks for overshoot timing
`default_nettype none
module rtd_carrier_timer #(
  parameter int LEN_W = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             start,
  input  wire logic [LEN_W-1:0] length,
  input  wire logic             carrier_tick,
  output logic                  busy
);
  logic [LEN_W-1:0] count_reg;
  logic [LEN_W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    // a restart wins over a tick landing in the same cycle
    if (start) begin
      count_next = length;
    end else if (carrier_tick && count_reg != '0) begin
      count_next = count_reg - LEN_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);
endmodule
`default_nettype wire

// *** verification/rtd_driver_config_props.sv ***
// assertion checker for the transmitter driver configuration block
`default_nettype none
module rtd_driver_config_props #(
  parameter int OVS_W = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        carrier_in,
  input wire logic        driver_out_first_o,
  input wire logic        driver_out_first_oe,
  input wire logic        driver_out_second_o,
  input wire logic        driver_out_second_oe,
  input wire logic [1:0]  carrier_level_reduction,
  input wire logic        carrier_full_level,
  input wire logic [4:0]  residual_level,
  input wire logic [3:0]  load_current_trim
);
  logic [11:0] aw_reg;
  logic [11:0] aw_next;
  logic [8:0]  wd_reg;
  logic [8:0]  wd_next;
  logic        bv_reg;
  logic [7:0]  sh_reg [4];
  logic [7:0]  sh_next [4];
  logic [7:0]  md;
  logic [2:0]  sty;
  assign md  = sh_reg[0];
  assign sty = sh_reg[0][2:0];

  always_comb begin
    aw_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_reg;
    wd_next = (s_axi_wvalid && s_axi_wready) ? {s_axi_wstrb[0], s_axi_wdata[7:0]} : wd_reg;
    sh_next = sh_reg;
    // shadow lags the register by one cycle, the same lag the outputs have
    if (s_axi_bvalid && !bv_reg && s_axi_bresp == rtd_pkg::RESP_OKAY && wd_reg[8]) begin
      sh_next[aw_reg[3:2]] = wd_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 12'h000;
      wd_reg <= 9'h000;
      bv_reg <= 1'b0;
      sh_reg <= '{default: 8'h00};
    end else begin
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      bv_reg <= s_axi_bvalid;
      sh_reg <= sh_next;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  // both halves are held for one cycle before the response register rises
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
  a_pins_off: assert property (!md[3] || sty == rtd_pkg::STYLE_HIGH_Z
    |-> !driver_out_first_oe && !driver_out_second_oe) else $error("pins driven while off");
  a_push_pull: assert property (md[3] && (sty == 3'h0 || sty == 3'h7)
    |-> driver_out_first_oe && driver_out_second_oe
    && driver_out_first_o == ($past(carrier_in) ^ md[6])
    && driver_out_second_o == ($past(carrier_in) ^ md[7])) else $error("push-pull pins wrong");
  a_open_drain: assert property (md[3] && sty == rtd_pkg::STYLE_OPEN_DRAIN
    |-> !driver_out_first_o && driver_out_first_oe == !($past(carrier_in) ^ md[6])
    && driver_out_second_oe == !($past(carrier_in) ^ md[7])) else $error("open drain wrong");
  a_forced_level: assert property (md[3] && sty inside {3'h4, 3'h5}
    |-> driver_out_first_oe && driver_out_second_oe && driver_out_first_o == sty[0]
    && driver_out_second_o == sty[0]) else $error("forced level wrong");
  a_level_mirror: assert property (residual_level == sh_reg[1][4:0]
    && load_current_trim == sh_reg[3][3:0]) else $error("level outputs wrong");
  a_full_override: assert property (carrier_full_level == sh_reg[2][3]
    && carrier_level_reduction == (sh_reg[2][3] ? 2'h0 : sh_reg[1][7:6]))
    else $error("amplitude override wrong");
endmodule

bind rtd_driver_config rtd_driver_config_props #(.OVS_W(OVS_W)) u_props (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .carrier_in, .driver_out_first_o,
  .driver_out_first_oe, .driver_out_second_o, .driver_out_second_oe, .carrier_level_reduction,
  .carrier_full_level, .residual_level, .load_current_trim);
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the transmitter driver configuration block
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = rtd_pkg::RESP_OKAY;
  localparam logic [1:0] ER = rtd_pkg::RESP_SLVERR;
  localparam logic [7:0] MSK [4] = '{rtd_pkg::MASK_DRIVER_MODE, rtd_pkg::MASK_CARRIER_AMP,
    rtd_pkg::MASK_MODULATION, rtd_pkg::MASK_OVERSHOOT_LD};
  localparam logic [2:0] STY [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
  logic        aclk = 1'b0, aresetn = 1'b0, carrier_in = 1'b0, carrier_tick = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        internal_envelope_signal = 1'b0, external_modulation_input = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, carrier_level_reduction, tick_cnt = 2'h0;
  logic [31:0] s_axi_rdata;
  logic        driver_out_first_o, driver_out_first_oe, driver_out_second_o;
  logic        driver_out_second_oe, carrier_full_level, modulation_active;
  logic        overshoot_first_active, overshoot_extra_active, e;
  logic [4:0]  residual_level;
  logic [3:0]  load_current_trim;
  logic [7:0]  d;
  logic [1:0]  exp_b [$];
  logic [33:0] exp_r [$];
  int          error_cnt = 0, n_checks = 0;

  rtd_driver_config #(.OVS_W(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_in, .carrier_tick,
    .internal_envelope_signal, .external_modulation_input, .driver_out_first_o,
    .driver_out_first_oe, .driver_out_second_o, .driver_out_second_oe,
    .carrier_level_reduction, .carrier_full_level, .residual_level, .load_current_trim,
    .modulation_active, .overshoot_first_active, .overshoot_extra_active);

  always #5 aclk = ~aclk;

  // random carrier keeps every pin assertion exercised; ticks every fourth cycle
  always @(posedge aclk) begin
    carrier_in <= 1'($urandom);
    tick_cnt <= tick_cnt + 2'h1;
    carrier_tick <= (tick_cnt == 2'h3);
  end

  function automatic logic [11:0] ra(input int i);
    return {2'h0, rtd_pkg::IDX_DRIVER_MODE + 8'(i), 2'h0};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] dd, input logic s,
                    input logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    exp_b.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, dd};
    s_axi_wstrb <= {3'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw |= s_axi_awvalid && s_axi_awready;
      w |= s_axi_wvalid && s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    // a late bready leaves the response standing for a while
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk iff s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] dd, input logic [1:0] r);
    exp_r.push_back({r, 24'h0, dd});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk iff s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      `CHK("bresp", exp_b.pop_front(), s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      `CHK("read", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata})
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h9904abfa));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ra(i), 8'h00, OK);
    repeat (3) for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      // software never writes the two unsupported style codes
      if (i == 0 && d[2:0] inside {3'h3, 3'h6}) d[2:0] = 3'h7;
      wr(ra(i), d, 1'b1, OK);
      rd(ra(i), d & MSK[i], OK);
    end
    foreach (STY[k]) begin
      wr(ra(0), {2'($urandom), 2'h0, k != 5, STY[k]}, 1'b1, OK);
      repeat (6) @(posedge aclk);
    end
    wr(12'h0B0, 8'hFF, 1'b1, ER);
    rd(12'h0B0, 8'h00, ER);
    wr(12'h0A1, 8'hFF, 1'b1, ER);
    rd(12'h0A1, 8'h00, ER);
    wr(ra(3), 8'h5A, 1'b1, OK);
    wr(ra(3), 8'hFF, 1'b0, OK);
    rd(ra(3), 8'h5A, OK);
    for (int f = 0; f < 2; f++) begin
      d = 8'($urandom);
      wr(ra(1), d, 1'b1, OK);
      wr(ra(2), {4'h0, f[0], 3'h0}, 1'b1, OK);
      repeat (3) @(posedge aclk);
      `CHK("reduction", f ? 2'h0 : d[7:6], carrier_level_reduction)
      `CHK("residual", d[4:0], residual_level)
    end
    // zero overshoot lengths so the output follows the source alone
    wr(ra(3), 8'h00, 1'b1, OK);
    for (int m = 0; m < 8; m++) begin
      wr(ra(2), {5'h00, m[2:0]}, 1'b1, OK);
      internal_envelope_signal <= 1'($urandom);
      external_modulation_input <= 1'($urandom);
      repeat (6) @(posedge aclk);
      e = (m[1:0] == 2'h1 && internal_envelope_signal);
      e = (e || (m[1:0] == 2'h2 && external_modulation_input)) ^ m[2];
      `CHK("modulation", e, modulation_active)
    end
    internal_envelope_signal <= 1'b0;
    wr(ra(3), 8'h35, 1'b1, OK);
    wr(ra(2), 8'h31, 1'b1, OK);
    repeat (20) @(posedge aclk);
    `CHK("trim", 4'h5, load_current_trim)
    internal_envelope_signal <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("first stage", 1'b1, overshoot_first_active)
    repeat (40) @(posedge aclk);
    `CHK("first done", 1'b0, overshoot_first_active)
    internal_envelope_signal <= 1'b0;
    repeat (5) @(posedge aclk);
    `CHK("extra stage", 2'h3, {overshoot_extra_active, modulation_active})
    repeat (40) @(posedge aclk);
    `CHK("extra done", 2'h0, {overshoot_extra_active, modulation_active})
    print_verdict();
  end
endmodule
`default_nettype wire
